/* File: src/vbus_discharge_charge_charge_limit_reached_flag.sv */
// vbus_discharge_charge_charge_limit_reached_flag.sv: bus discharge control and charge rationing
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "vdc_cfg.svh"

module vbus_discharge_charge_charge_limit_reached_flag #(
  parameter int unsigned DISCH_CYCLES = `VDC_DISCH_CYCLES,
  parameter int unsigned ACC_W = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire vdc_pkg::vdc_pins_s pinsIn,
  input wire vdc_pkg::vdc_events_s eventsIn,
  input wire logic [15:0] busCurrent,
  output logic dischargeOn,
  output logic portSwitchOn,
  output logic bypassSwitchOn,
  output logic profileOn,
  output logic dataPathSwitch,
  output logic monitorOn,
  output logic attentionOutN,
  output vdc_pkg::vdc_pstate_e powerState
);
  initial begin
    if (DISCH_CYCLES < 1 || DISCH_CYCLES > 32'hFFFFFF || ACC_W < 16 || ACC_W > 32)
      $error("unsupported parameter value");
  end

  // two-stage synchronisers for pins and analog event comparators
  vdc_pkg::vdc_pins_s pinMeta_q, pinSync_q, pinPrev_q, pinSample_q;
  vdc_pkg::vdc_events_s evMeta_q, evSync_q, evPrev_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
      evMeta_q <= '0;
      evSync_q <= '0;
    end else begin
      pinMeta_q <= pinsIn;
      pinSync_q <= pinMeta_q;
      evMeta_q <= eventsIn;
      evSync_q <= evMeta_q;
    end
  end

  // bus slave: one wait-free data phase
  logic wrPend_q, rdPend_q;
  logic [11:0] addrPend_q;
  logic [31:0] ctrl_q, limit_q;
  logic [ACC_W-1:0] accum_q;
  logic drainFault_q, limitReached_q;
  wire busSel = hsel && hready && htrans[1];
  wire wrCtrl = wrPend_q && addrPend_q == `VDC_OFF_CTRL;
  wire wrLimit = wrPend_q && addrPend_q == `VDC_OFF_LIMIT;
  wire wrStat = wrPend_q && addrPend_q == `VDC_OFF_STAT;
  wire swDischarge = wrCtrl && hwdata[`VDC_CTRL_DISCH_BIT];
  wire swRatReset = wrCtrl && hwdata[`VDC_CTRL_RATRST_BIT];
  wire ratEnable = ctrl_q[`VDC_CTRL_RATEN_BIT];
  wire pwrUpSkip = ctrl_q[`VDC_CTRL_PWRUP_SKIP_BIT];
  wire vdc_pkg::vdc_action_e action =
    vdc_pkg::vdc_action_e'(ctrl_q[`VDC_CTRL_ACT_LSB +: 2]);

  function automatic logic [31:0] readMux(input logic [11:0] a, input logic [31:0] c,
      input logic [31:0] s, input logic [31:0] l, input logic [31:0] q,
      input logic [31:0] p);
    case (a)
      `VDC_OFF_CTRL: readMux = c;
      `VDC_OFF_STAT: readMux = s;
      `VDC_OFF_LIMIT: readMux = l;
      `VDC_OFF_ACCUM: readMux = q;
      `VDC_OFF_SAMPLE: readMux = p;
      default: readMux = 32'h0000_0000;
    endcase
  endfunction

  vdc_pkg::vdc_pstate_e state_q, state_d;
  wire [31:0] statWord = {25'h0, state_q, 2'h0, limitReached_q, drainFault_q};
  wire [31:0] accWord = 32'(accum_q);
  wire [31:0] pinWord = {27'h0, pinSync_q};
  wire [31:0] rdValue = readMux(haddr[11:0], ctrl_q & 32'h0000_0132, statWord, limit_q,
    accWord, pinWord);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      addrPend_q <= 12'h000;
      hrdata <= 32'h0000_0000;
    end else begin
      wrPend_q <= busSel && hwrite;
      rdPend_q <= busSel && !hwrite;
      addrPend_q <= haddr[11:0];
      hrdata <= (busSel && !hwrite) ? rdValue : 32'h0000_0000;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // action written at any time, accumulation untouched
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= 32'(`VDC_ACT_RESET) << `VDC_CTRL_ACT_LSB;
      limit_q <= 32'h0000_0000;
    end else begin
      if (wrCtrl)
        ctrl_q <= hwdata & 32'h0000_0132;
      if (wrLimit)
        limit_q <= hwdata;
    end
  end

  // mode decode: Sleep when emulation enable and both mode pins are all low
  function automatic vdc_pkg::vdc_pstate_e pinState(input vdc_pkg::vdc_pins_s p);
    if (!p.emulationEnable && !p.modeSelectOne && !p.modeSelectTwo)
      pinState = vdc_pkg::PS_SLEEP;
    else if (p.powerEnable && !p.bypassEnable)
      pinState = vdc_pkg::PS_ACTIVE;
    else
      pinState = vdc_pkg::PS_DETECT;
  endfunction

  wire vdc_pkg::vdc_pstate_e pinTarget = pinState(pinSync_q);
  wire isActive = state_q == vdc_pkg::PS_ACTIVE;
  wire limitHit = ratEnable && isActive && (32'(accum_q) >= limit_q);
  wire holdSleep = limitReached_q && action == vdc_pkg::ACT_DISC_SLEEP;
  wire holdDisc = limitReached_q && action == vdc_pkg::ACT_REPORT_DISC;
  wire ratRelease = limitReached_q && (swRatReset || !ratEnable);
  wire pinsChanged = pinSync_q != pinSample_q;

  // discharge triggers
  wire trigPwrOff = pinPrev_q.powerEnable && !pinSync_q.powerEnable && !holdSleep;
  wire trigRemoval = evSync_q.removalEvent && !evPrev_q.removalEvent;
  wire trigUvlo = evSync_q.supplyUnderVoltage && !evPrev_q.supplyUnderVoltage
    && portSwitchOn && monitorOn;
  wire trigSleep = state_d == vdc_pkg::PS_SLEEP && state_q != vdc_pkg::PS_SLEEP;
  wire trigProfile = evSync_q.profileRequest && !evPrev_q.profileRequest
    && !(pwrUpSkip && evSync_q.powerUp);
  wire trigErrRec = state_q == vdc_pkg::PS_ERROR && evSync_q.errorRecover;
  wire trigSw = swDischarge && isActive;
  logic portOn_d, bypassOn_d;
  wire trigPortAfterByp = portOn_d && !portSwitchOn && bypassSwitchOn;
  wire trigBypAfterPort = bypassOn_d && !bypassSwitchOn && portSwitchOn;
  wire quietReturn = ratRelease && !pinsChanged;
  wire startDisch = !quietReturn && (trigPwrOff || trigRemoval || trigUvlo || trigSleep
    || trigProfile || trigErrRec || trigSw || trigPortAfterByp || trigBypAfterPort);

  // power state
  always_comb begin
    state_d = state_q;
    if (state_q == vdc_pkg::PS_ERROR) begin
      if (evSync_q.errorRecover)
        state_d = pinTarget;
    end else if (holdSleep && !ratRelease) begin
      state_d = vdc_pkg::PS_SLEEP;
    end else if (ratRelease && !pinsChanged) begin
      state_d = state_q;
    end else begin
      state_d = pinTarget;
    end
  end
  always_comb begin
    portOn_d = state_d == vdc_pkg::PS_ACTIVE && !(holdDisc || holdSleep)
      || (ratRelease && state_d == vdc_pkg::PS_ACTIVE);
    bypassOn_d = state_d == vdc_pkg::PS_DETECT && !holdDisc && !holdSleep;
  end

  // discharge wait counter, reloaded by every trigger not masked by quietReturn
  logic [23:0] dischCnt_q;
  logic checkDue;
  assign checkDue = dischargeOn && dischCnt_q == 24'h00_0001;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dischCnt_q <= 24'h00_0000;
      dischargeOn <= 1'b0;
    end else if (startDisch) begin
      dischCnt_q <= 24'(DISCH_CYCLES);
      dischargeOn <= 1'b1;
    end else if (dischargeOn) begin
      dischCnt_q <= dischCnt_q - 24'h00_0001;
      dischargeOn <= !checkDue;
    end
  end
  wire dischFail = checkDue && !evSync_q.busBelowCheck;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= vdc_pkg::PS_SLEEP;
      portSwitchOn <= 1'b0;
      bypassSwitchOn <= 1'b0;
      pinPrev_q <= '0;
      evPrev_q <= '0;
    end else begin
      state_q <= dischFail ? vdc_pkg::PS_ERROR : state_d;
      portSwitchOn <= portOn_d && !dischFail;
      bypassSwitchOn <= bypassOn_d && !dischFail;
      pinPrev_q <= pinSync_q;
      evPrev_q <= evSync_q;
    end
  end

  // sticky fault flag: a set beats a software clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      drainFault_q <= 1'b0;
    else if (dischFail)
      drainFault_q <= 1'b1;
    else if (wrStat && hwdata[0])
      drainFault_q <= 1'b0;
  end

  // charge accumulation: current summed each cycle while Active, rationing enabled and limit not reached
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      accum_q <= '0;
      limitReached_q <= 1'b0;
      pinSample_q <= '0;
    end else begin
      if (swRatReset) begin
        accum_q <= '0;
      end else if (ratEnable && isActive && !limitReached_q) begin
        accum_q <= accum_q + ACC_W'(busCurrent);
      end
      if (limitHit && !limitReached_q) begin
        limitReached_q <= 1'b1;
        pinSample_q <= pinSync_q;
      end else if (swRatReset || !ratEnable) begin
        limitReached_q <= 1'b0;
      end
    end
  end

  // outputs decided by the selected action
  wire reportMode = action == vdc_pkg::ACT_REPORT || action == vdc_pkg::ACT_REPORT_DISC;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      attentionOutN <= 1'b1;
      profileOn <= 1'b0;
      dataPathSwitch <= 1'b0;
      monitorOn <= 1'b1;
      powerState <= vdc_pkg::PS_SLEEP;
    end else begin
      attentionOutN <= !(limitReached_q && reportMode && !ratRelease);
      profileOn <= pinSync_q.emulationEnable && state_d != vdc_pkg::PS_SLEEP
        && !startDisch && !dischargeOn && !((holdDisc || holdSleep) && !ratRelease);
      dataPathSwitch <= !(holdSleep && !ratRelease) && state_d != vdc_pkg::PS_SLEEP;
      monitorOn <= !(holdSleep && !ratRelease);
      powerState <= dischFail ? vdc_pkg::PS_ERROR : state_d;
    end
  end

  a_fault_to_error: assert property (@(posedge clk) disable iff (!resetn)
    dischFail |=> state_q == vdc_pkg::PS_ERROR && drainFault_q)
    else $error("discharge failure did not enter error");
  a_limit_no_error: assert property (@(posedge clk) disable iff (!resetn)
    $rose(limitReached_q) && !dischFail |-> state_q != vdc_pkg::PS_ERROR)
    else $error("limit reached caused error state");
  a_sw_disch_active: assert property (@(posedge clk) disable iff (!resetn)
    trigSw |=> dischargeOn && dischCnt_q == 24'(DISCH_CYCLES))
    else $error("software discharge not started");
  a_disc_switch_off: assert property (@(posedge clk) disable iff (!resetn)
    holdDisc && !ratRelease |=> !portSwitchOn && !bypassSwitchOn)
    else $error("switch on during report and disconnect");
  a_sleep_monitor_off: assert property (@(posedge clk) disable iff (!resetn)
    holdSleep && !ratRelease |=> !monitorOn && !dataPathSwitch)
    else $error("monitoring active during disconnect and sleep");
  a_reset_clears: assert property (@(posedge clk) disable iff (!resetn)
    swRatReset |=> accum_q == '0 && !limitReached_q)
    else $error("rationing reset did not clear");
  a_attn_release: assert property (@(posedge clk) disable iff (!resetn)
    ratRelease && reportMode |=> attentionOutN)
    else $error("attention not released on rationing reset");
  a_pwr_off_disch: assert property (@(posedge clk) disable iff (!resetn)
    trigPwrOff && !quietReturn |=> dischargeOn)
    else $error("power enable fall did not discharge");
  a_charge_limit_reached_flag_active: assert property (@(posedge clk) disable iff (!resetn)
    !isActive && !swRatReset |=> $stable(accum_q))
    else $error("charge accumulated outside active");
  a_write_keeps_acc: assert property (@(posedge clk) disable iff (!resetn)
    wrCtrl && !swRatReset && !(ratEnable && isActive && !limitReached_q)
    |=> $stable(accum_q))
    else $error("action write changed accumulated charge");
endmodule
`default_nettype wire

/* File: src/vdc_cfg.svh */
// vdc_cfg.svh: register offsets, field positions, reset values and timing counts
`ifndef VDC_CFG_SVH
`define VDC_CFG_SVH
`define VDC_OFF_CTRL 12'h000
`define VDC_OFF_STAT 12'h004
`define VDC_OFF_LIMIT 12'h008
`define VDC_OFF_ACCUM 12'h00C
`define VDC_OFF_SAMPLE 12'h010
`define VDC_CTRL_DISCH_BIT 0
`define VDC_CTRL_RATEN_BIT 1
`define VDC_CTRL_RATRST_BIT 2
`define VDC_CTRL_ACT_LSB 4
`define VDC_CTRL_PWRUP_SKIP_BIT 8
`define VDC_ACT_RESET 2'h1
`define VDC_DISCH_TIME_NS 200000
`define VDC_CLK_PERIOD_NS 5
`define VDC_DISCH_CYCLES (`VDC_DISCH_TIME_NS / `VDC_CLK_PERIOD_NS)
`endif

/* File: src/vdc_pkg.sv */
// vdc_pkg.sv: types of the discharge and charge rationing controller
package vdc_pkg;
  typedef enum logic [1:0] {
    ACT_REPORT = 2'h0,
    ACT_REPORT_DISC = 2'h1,
    ACT_DISC_SLEEP = 2'h2,
    ACT_IGNORE = 2'h3
  } vdc_action_e;
  typedef enum logic [2:0] {
    PS_SLEEP = 3'h0,
    PS_DETECT = 3'h1,
    PS_ACTIVE = 3'h3,
    PS_ERROR = 3'h2
  } vdc_pstate_e;
  typedef struct packed {
    logic powerEnable;
    logic emulationEnable;
    logic modeSelectOne;
    logic modeSelectTwo;
    logic bypassEnable;
  } vdc_pins_s;
  typedef struct packed {
    logic removalEvent;
    logic supplyUnderVoltage;
    logic profileRequest;
    logic powerUp;
    logic errorRecover;
    logic busBelowCheck;
  } vdc_events_s;
endpackage

/* File: bench/vdc_port_model.sv */
// port side model: bus level seen by the discharge check, and load current
`timescale 1ns/10ps
`default_nettype none
module vdc_port_model #(
  parameter logic [15:0] LOAD = 16'h0010
) (
  input wire logic clk,
  input wire logic dischargeOn,
  input wire logic portSwitchOn,
  input wire logic bypassSwitchOn,
  input wire logic stuckHigh,
  input wire logic slow,
  output logic busBelow,
  output logic [15:0] busCurrent
);
  logic [1:0] level_q = 2'h3;
  logic tick_q = 1'b0;
  always_ff @(posedge clk) begin
    tick_q <= ~tick_q;
    // the resistor wins over any source; slow decay still ends inside the wait
    if (dischargeOn) begin
      if ((!slow || tick_q) && level_q != 2'h0) begin
        level_q <= level_q - 2'h1;
      end
    end else if (portSwitchOn || bypassSwitchOn) begin
      level_q <= 2'h3;
    end
  end
  // a broken resistor keeps the bus up, only when the bench asks for it
  assign busBelow = (level_q == 2'h0) && !stuckHigh;
  assign busCurrent = portSwitchOn ? LOAD : 16'h0000;
endmodule
`default_nettype wire

/* File: bench/vbus_discharge_charge_charge_limit_reached_flag_test.sv */
// self-checking bench of the discharge and charge rationing block
`timescale 1ns/10ps
`default_nettype none
`include "vdc_cfg.svh"
module vbus_discharge_charge_charge_limit_reached_flag_test;
  localparam logic [4:0] P_ACT = 5'b11000;
  localparam logic [4:0] P_DET = 5'b11001;
  localparam logic [4:0] P_OFF = 5'b01000;
  localparam logic [4:0] P_SLP = 5'b10000;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hwrite = 1'b0;
  logic hsel = 1'b0;
  logic hreadyout, hresp, busBelow, dpKeep;
  vdc_pkg::vdc_pins_s pins = 5'h00;
  logic [4:0] evBits = 5'h00;
  logic stuck = 1'b0;
  logic slow = 1'b0;
  logic [15:0] busCurrent;
  logic dischargeOn, portSwitchOn, bypassSwitchOn, profileOn, dataPathSwitch, monitorOn;
  logic attentionOutN;
  vdc_pkg::vdc_pstate_e powerState;
  int mismatches = 0;
  int n_checks = 0;
  int evOrder[3] = '{2, 4, 3};

  always #2.5 clk = ~clk;

  // wait long enough for the slow decay plus the two-flop sync of the level
  vbus_discharge_charge_charge_limit_reached_flag #(.DISCH_CYCLES(12), .ACC_W(32)) u_dut (
    .clk(clk), .resetn(resetn), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hsel(hsel), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pinsIn(pins), .eventsIn({evBits, busBelow}),
    .busCurrent(busCurrent), .dischargeOn(dischargeOn), .portSwitchOn(portSwitchOn),
    .bypassSwitchOn(bypassSwitchOn), .profileOn(profileOn), .dataPathSwitch(dataPathSwitch),
    .monitorOn(monitorOn), .attentionOutN(attentionOutN), .powerState(powerState));

  vdc_port_model u_port (.clk(clk), .dischargeOn(dischargeOn), .portSwitchOn(portSwitchOn),
    .bypassSwitchOn(bypassSwitchOn), .stuckHigh(stuck), .slow(slow), .busBelow(busBelow),
    .busCurrent(busCurrent));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // single word transfer; read data is taken at the edge ending the data phase
  task automatic xfer(input logic [11:0] a, input logic wr, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic setPins(input logic [4:0] p);
    pins <= p;
    cyc(20);
  endtask

  // watches for the resistor, then lets the wait and check run out
  task automatic disch(input logic exp, input string what);
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      @(posedge clk);
      #1 seen = seen | dischargeOn;
    end
    chk(what, {31'h0, seen}, {31'h0, exp});
    cyc(16);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    cyc(20000);
    mismatches++;
    close_out;
  end

  initial begin
    logic [31:0] acc;
    cyc(5);
    resetn <= 1'b1;
    cyc(2);
    chk("state", {29'h0, powerState}, {29'h0, vdc_pkg::PS_SLEEP});
    chk("attn", {31'h0, attentionOutN}, 32'h1);
    xfer(`VDC_OFF_CTRL, 1'b0, 32'h0);
    chk("ctrl", rd, 32'h10);
    xfer(12'h040, 1'b1, 32'hFFFF_FFFF);
    xfer(12'h040, 1'b0, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("test reset done");
    setPins(P_ACT);
    chk("state", {29'h0, powerState}, {29'h0, vdc_pkg::PS_ACTIVE});
    slow <= 1'b1;
    xfer(`VDC_OFF_CTRL, 1'b1, 32'h11);
    disch(1'b1, "cmdActive");
    pins <= P_DET;
    disch(1'b1, "toDetect");
    xfer(`VDC_OFF_CTRL, 1'b1, 32'h11);
    disch(1'b0, "cmdDetect");
    pins <= P_ACT;
    disch(1'b1, "toActive");
    pins <= P_OFF;
    disch(1'b1, "pwrOff");
    setPins(P_ACT);
    pins <= P_SLP;
    disch(1'b1, "sleep");
    setPins(P_ACT);
    slow <= 1'b0;
    chk("state", {29'h0, powerState}, {29'h0, vdc_pkg::PS_ACTIVE});
    $display("test triggers done");
    stuck <= 1'b1;
    xfer(`VDC_OFF_CTRL, 1'b1, 32'h11);
    cyc(20);
    xfer(`VDC_OFF_STAT, 1'b0, 32'h0);
    chk("fault", rd, 32'h21);
    stuck <= 1'b0;
    evBits[0] <= 1'b1;
    disch(1'b1, "recover");
    evBits[0] <= 1'b0;
    xfer(`VDC_OFF_STAT, 1'b1, 32'h1);
    cyc(10);
    chk("state", {29'h0, powerState}, {29'h0, vdc_pkg::PS_ACTIVE});
    $display("test fault done");
    xfer(`VDC_OFF_LIMIT, 1'b1, 32'h100);
    for (int a = 0; a < 4; a++) begin
      dpKeep = dataPathSwitch;
      xfer(`VDC_OFF_CTRL, 1'b1, {26'h0, a[1:0], 4'h2});
      cyc(60);
      xfer(`VDC_OFF_STAT, 1'b0, 32'h0);
      chk("reached", rd, a == 2 ? 32'h02 : 32'h32);
      chk("attn", {31'h0, attentionOutN}, {31'h0, a > 1});
      chk("port", {31'h0, portSwitchOn}, {31'h0, a[0] == a[1]});
      chk("dpath", {31'h0, dataPathSwitch}, {31'h0, a == 2 ? 1'b0 : dpKeep});
      chk("mon", {31'h0, monitorOn}, {31'h0, a != 2});
      if (a == 1 || a == 2) begin
        chk("profile", {31'h0, profileOn}, 32'h0);
        setPins(P_DET);
        chk("moved", {29'h0, powerState}, a == 1 ? 32'h1 : 32'h0);
        chk("bypass", {31'h0, bypassSwitchOn}, 32'h0);
        setPins(P_ACT);
      end
      if (a == 3) begin
        setPins(P_DET);
        xfer(`VDC_OFF_ACCUM, 1'b0, 32'h0);
        acc = rd;
        xfer(`VDC_OFF_CTRL, 1'b1, 32'h02);
        xfer(`VDC_OFF_ACCUM, 1'b0, 32'h0);
        chk("accum", rd, acc);
        setPins(P_ACT);
      end
      // reset pulse with enable off, so nothing accumulates while reading back
      xfer(`VDC_OFF_CTRL, 1'b1, {26'h0, a[1:0], 4'h4});
      disch(1'b0, "resume");
      xfer(`VDC_OFF_ACCUM, 1'b0, 32'h0);
      chk("cleared", rd, 32'h0);
      xfer(`VDC_OFF_STAT, 1'b0, 32'h0);
      chk("flag", rd, 32'h30);
      chk("attn", {31'h0, attentionOutN}, 32'h1);
      $display("test action %0d done", a);
    end
    xfer(`VDC_OFF_CTRL, 1'b1, 32'h110);
    evBits[2:1] <= 2'b11;
    disch(1'b0, "skipPwrUp");
    evBits[2:1] <= 2'b00;
    cyc(4);
    // undervoltage last: it may leave the port off for what follows
    foreach (evOrder[k]) begin
      evBits[evOrder[k]] <= 1'b1;
      disch(1'b1, "event");
      evBits[evOrder[k]] <= 1'b0;
      setPins(P_ACT);
    end
    $display("test events done");
    close_out;
  end
endmodule
`default_nettype wire
